// ===== verilog/ccit_pkg.sv
// constants for the control channel and local i2c timing block
package ccit_pkg;
  // register offsets (byte-wide registers on the local register port)
  localparam logic [7:0] CCIT_ADDR_LINK_WD = 8'h08;
  localparam logic [7:0] CCIT_ADDR_I2C_A = 8'h09;
  localparam logic [7:0] CCIT_ADDR_I2C_B = 8'h0a;
  localparam logic [7:0] CCIT_ADDR_SCL_HI = 8'h0b;
  localparam logic [7:0] CCIT_ADDR_SCL_LO = 8'h0c;
  // reset values
  localparam logic [7:0] CCIT_RST_LINK_WD = 8'hfe;
  localparam logic [7:0] CCIT_RST_I2C_A = 8'h1e;
  localparam logic [7:0] CCIT_RST_I2C_B = 8'h10;
  localparam logic [7:0] CCIT_RST_SCL_HI = 8'h7f;
  localparam logic [7:0] CCIT_RST_SCL_LO = 8'h7f;
  // field positions
  localparam int CCIT_WD_OFF_BIT = 0;
  localparam int CCIT_WD_CNT_LSB = 1;
  localparam int CCIT_RWB_BIT = 7;
  localparam int CCIT_HOLD_LSB = 4;
  localparam int CCIT_FILT_LSB = 0;
  localparam int CCIT_SETUP_LSB = 4;
  localparam int CCIT_DLY_LSB = 2;
  localparam int CCIT_FAST_BIT = 1;
  localparam int CCIT_HANG_OFF_BIT = 0;
  // timing, system clock 250 mhz
  localparam int CCIT_CLK_MHZ = 250;
  localparam int CCIT_CLK_PS = 4000;
  localparam int CCIT_LINK_UNIT_MS = 2;
  localparam int CCIT_LINK_UNIT_CYC = CCIT_LINK_UNIT_MS * CCIT_CLK_MHZ * 1000;
  localparam int CCIT_HOLD_UNIT_NS = 50;
  localparam int CCIT_HOLD_UNIT_CYC = CCIT_HOLD_UNIT_NS * 1000 / CCIT_CLK_PS;
  localparam int CCIT_FILT_UNIT_NS = 5;
  // 5 ns rounds up to two 4 ns cycles
  localparam int CCIT_FILT_UNIT_CYC =
    (CCIT_FILT_UNIT_NS * 1000 + CCIT_CLK_PS - 1) / CCIT_CLK_PS;
  localparam int CCIT_SETUP_BASE_NS = 80;
  localparam int CCIT_SETUP_UNIT_NS = 640;
  localparam int CCIT_SETUP_BASE_CYC = CCIT_SETUP_BASE_NS * 1000 / CCIT_CLK_PS;
  localparam int CCIT_SETUP_UNIT_CYC = CCIT_SETUP_UNIT_NS * 1000 / CCIT_CLK_PS;
  localparam int CCIT_DLY_BASE_NS = 240;
  localparam int CCIT_DLY_UNIT_NS = 40;
  localparam int CCIT_DLY_BASE_CYC = CCIT_DLY_BASE_NS * 1000 / CCIT_CLK_PS;
  localparam int CCIT_DLY_UNIT_CYC = CCIT_DLY_UNIT_NS * 1000 / CCIT_CLK_PS;
  localparam int CCIT_OSC_PS = 38095;
  // one oscillator period, rounded up to system cycles
  localparam int CCIT_OSC_CYC = (CCIT_OSC_PS + CCIT_CLK_PS - 1) / CCIT_CLK_PS;
  localparam int CCIT_OSC_EXTRA = 5;
  localparam int CCIT_HANG_FAST_US = 50;
  localparam int CCIT_HANG_SLOW_MS = 1000;
  localparam int CCIT_HANG_FAST_CYC = CCIT_HANG_FAST_US * CCIT_CLK_MHZ;
  localparam int CCIT_HANG_SLOW_CYC = CCIT_HANG_SLOW_MS * CCIT_CLK_MHZ * 1000;
  localparam int CCIT_RECOVER_PULSES = 9;
  typedef enum logic [1:0]
  {
    CCIT_ST_IDLE = 2'b00,
    CCIT_ST_LOW = 2'b01,
    CCIT_ST_HIGH = 2'b11
  } ccit_rec_e;
endpackage

// ===== verilog/ccit_filter.sv
// glitch filter plus delayed copy for one i2c input line
`timescale 1ns/10ps
`default_nettype none
module ccit_filter
  import ccit_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_line,
  input wire logic [7:0] i_filt_cyc,
  input wire logic [7:0] i_hold_cyc,
  output logic o_line
);
  logic stable_q;
  logic [7:0] cnt_q;
  logic [7:0] hold_q;
  logic held_q;
  logic filt_q;
  // a change is accepted only after it outlasts the filter depth
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      stable_q <= 1'b1;
      cnt_q <= 8'h00;
    end
    else if (i_line == stable_q)
    begin
      cnt_q <= 8'h00;
    end
    else if (cnt_q >= i_filt_cyc)
    begin
      stable_q <= i_line;
      cnt_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // extra hold: the filtered value follows after i_hold_cyc cycles
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      hold_q <= 8'h00;
      held_q <= 1'b1;
    end
    else if (stable_q == held_q)
    begin
      hold_q <= 8'h00;
    end
    else if (hold_q >= i_hold_cyc)
    begin
      held_q <= stable_q;
      hold_q <= 8'h00;
    end
    else
    begin
      hold_q <= hold_q + 8'h01;
    end
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      filt_q <= 1'b1;
    else
      filt_q <= held_q;
  end
  assign o_line = filt_q;
endmodule
`default_nettype wire

// ===== verilog/ccit_top.sv
// control channel watchdog, write guard and local i2c timing
// Contract
// R01: link timeout field bits 7:1, 2 ms units
// R02: unfinished link transaction terminated on timeout
// R03: software never programs timeout zero
// R04: bit 0 set stops link watchdog
// R05: block bit rejects remote local writes
// R06: forwarded remote accesses never blocked
// R07: sda input hold bits 6:4, 50 ns
// R08: glitch filter depth bits 3:0, 5 ns
// R09: ack sda setup 80 ns plus 640/count
// R10: sda delay 240 ns plus 40/step
// R11: hang timer 50 us fast, 1 s slow
// R12: bit 0 disables bus hang watchdog
// R13: sda high idle one second: bus free; code declares it after the selected hang time, 50 us when fast
// R14: sda low idle expiry: nine scl pulses
// R15: scl high count field bits 7:0
// R16: scl high is field plus five periods
// R17: scl low is field plus five periods
// R18: link timer restarts per transaction, stops at end
// R19: hang timer restarts on any line change
`timescale 1ns/10ps
`default_nettype none
module ccit_top
  import ccit_pkg::*;
#(
  parameter int LINK_UNIT_CYC = CCIT_LINK_UNIT_CYC,
  parameter int HANG_FAST_CYC = CCIT_HANG_FAST_CYC,
  parameter int HANG_SLOW_CYC = CCIT_HANG_SLOW_CYC
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // local register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_remote,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_wr_rejected,
  // control link transaction
  input wire logic i_link_start,
  input wire logic i_link_done,
  output logic o_link_abort,
  output logic o_link_busy,
  // local i2c pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_bus_free,
  output logic o_bus_recovering,
  // derived timing, system cycles
  output logic [11:0] o_sda_setup_cyc,
  output logic [7:0] o_sda_delay_cyc,
  output logic [11:0] o_scl_high_cyc,
  output logic [11:0] o_scl_low_cyc
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] link_wd_q;
  logic [7:0] i2c_a_q;
  logic [7:0] i2c_b_q;
  logic [7:0] scl_hi_q;
  logic [7:0] scl_lo_q;
  logic [7:0] rdata_q;
  logic rej_q;
  wire wr_ok = i_reg_wr && !(i_reg_remote && i2c_a_q[CCIT_RWB_BIT]); // see R05
  // remote writes forwarded to the local bus do not use this port
  // see R06
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      link_wd_q <= CCIT_RST_LINK_WD;
      i2c_a_q <= CCIT_RST_I2C_A;
      i2c_b_q <= CCIT_RST_I2C_B;
      scl_hi_q <= CCIT_RST_SCL_HI;
      scl_lo_q <= CCIT_RST_SCL_LO;
    end
    else if (wr_ok)
    begin
      case (i_reg_addr)
        CCIT_ADDR_LINK_WD: link_wd_q <= i_reg_wdata; // see R01 R04
        CCIT_ADDR_I2C_A: i2c_a_q <= i_reg_wdata;
        CCIT_ADDR_I2C_B: i2c_b_q <= i_reg_wdata;
        CCIT_ADDR_SCL_HI: scl_hi_q <= i_reg_wdata; // see R15
        CCIT_ADDR_SCL_LO: scl_lo_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end
  logic [7:0] rsel;
  assign rsel = (i_reg_addr == CCIT_ADDR_LINK_WD) ? link_wd_q :
                (i_reg_addr == CCIT_ADDR_I2C_A) ? i2c_a_q :
                (i_reg_addr == CCIT_ADDR_I2C_B) ? i2c_b_q :
                (i_reg_addr == CCIT_ADDR_SCL_HI) ? scl_hi_q :
                (i_reg_addr == CCIT_ADDR_SCL_LO) ? scl_lo_q : 8'h00;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      rdata_q <= 8'h00;
      rej_q <= 1'b0;
    end
    else
    begin
      if (i_reg_rd)
        rdata_q <= rsel;
      rej_q <= i_reg_wr && !wr_ok; // see R05
    end
  end
  // ----------------------------------------------------------------
  // control link watchdog
  // ----------------------------------------------------------------
  logic [6:0] lw_units_q;
  logic [31:0] lw_cyc_q;
  logic lw_busy_q;
  logic lw_abort_q;
  wire lw_off = link_wd_q[CCIT_WD_OFF_BIT]; // see R04
  wire [6:0] lw_cnt = link_wd_q[7:CCIT_WD_CNT_LSB]; // see R01
  // a zero count expires at once; software must avoid it, see R03
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lw_units_q <= 7'h00;
      lw_cyc_q <= 32'h0;
      lw_busy_q <= 1'b0;
      lw_abort_q <= 1'b0;
    end
    else
    begin
      lw_abort_q <= 1'b0;
      if (i_link_start)
      begin
        lw_units_q <= lw_cnt; // see R18
        lw_cyc_q <= 32'h0;
        lw_busy_q <= 1'b1;
      end
      else if (i_link_done)
        lw_busy_q <= 1'b0; // see R18
      else if (lw_busy_q && !lw_off)
      begin
        if (lw_units_q == 7'h00)
        begin
          lw_busy_q <= 1'b0;
          lw_abort_q <= 1'b1; // see R02
        end
        else if (lw_cyc_q == 32'(LINK_UNIT_CYC - 1))
        begin
          lw_cyc_q <= 32'h0;
          lw_units_q <= lw_units_q - 7'h01;
        end
        else
          lw_cyc_q <= lw_cyc_q + 32'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // input synchronisers and filters
  // ----------------------------------------------------------------
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
    end
  end
  logic [7:0] filt_cyc;
  logic [7:0] hold_cyc;
  assign filt_cyc = 8'(32'(i2c_a_q[3:CCIT_FILT_LSB]) *
                       CCIT_FILT_UNIT_CYC); // see R08
  assign hold_cyc = 8'(32'(i2c_a_q[6:CCIT_HOLD_LSB]) *
                       CCIT_HOLD_UNIT_CYC); // see R07
  logic scl_f;
  logic sda_f;
  ccit_filter u_scl_filt
  (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_line(scl_s_q[1]),
    .i_filt_cyc(filt_cyc),
    .i_hold_cyc(8'h00),
    .o_line(scl_f)
  );
  // hold applies to sda only, relative to scl
  ccit_filter u_sda_filt
  (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_line(sda_s_q[1]),
    .i_filt_cyc(filt_cyc),
    .i_hold_cyc(hold_cyc),
    .o_line(sda_f)
  );
  // ----------------------------------------------------------------
  // bus hang watchdog and nine-clock recovery
  // ----------------------------------------------------------------
  logic scl_p_q;
  logic sda_p_q;
  logic [31:0] hang_q;
  logic free_q;
  ccit_rec_e rec_q;
  logic [3:0] pulses_q;
  logic [11:0] ph_q;
  logic scl_o_q;
  logic scl_oe_q;
  wire hang_off = i2c_b_q[CCIT_HANG_OFF_BIT]; // see R12
  wire [31:0] hang_lim = i2c_b_q[CCIT_FAST_BIT] ? 32'(HANG_FAST_CYC) :
                         32'(HANG_SLOW_CYC); // see R11
  wire activity = (scl_f != scl_p_q) || (sda_f != sda_p_q);
  wire expired = !hang_off && (hang_q >= hang_lim - 32'h1);
  logic [11:0] hi_cyc;
  logic [11:0] lo_cyc;
  assign hi_cyc = 12'(32'(scl_hi_q) * CCIT_OSC_CYC +
                      CCIT_OSC_EXTRA * CCIT_OSC_CYC); // see R16
  assign lo_cyc = 12'(32'(scl_lo_q) * CCIT_OSC_CYC +
                      CCIT_OSC_EXTRA * CCIT_OSC_CYC); // see R17
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      hang_q <= 32'h0;
      free_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      if (activity || hang_off || rec_q != CCIT_ST_IDLE)
      begin
        hang_q <= 32'h0; // see R19
        if (activity)
          free_q <= 1'b0;
      end
      else if (expired)
      begin
        hang_q <= 32'h0;
        free_q <= sda_f; // see R13
      end
      else
        hang_q <= hang_q + 32'h1;
    end
  end
  // recovery pulls scl low and releases it nine times with master timing
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      rec_q <= CCIT_ST_IDLE;
      pulses_q <= 4'h0;
      ph_q <= 12'h000;
      scl_o_q <= 1'b1;
      scl_oe_q <= 1'b0;
    end
    else
    begin
      case (rec_q)
        CCIT_ST_IDLE:
        begin
          if (expired && !activity && !sda_f)
          begin
            rec_q <= CCIT_ST_LOW; // see R14
            pulses_q <= 4'h0;
            ph_q <= 12'h000;
            scl_o_q <= 1'b0;
            scl_oe_q <= 1'b1;
          end
        end
        CCIT_ST_LOW:
        begin
          if (ph_q >= lo_cyc - 12'h001)
          begin
            rec_q <= CCIT_ST_HIGH;
            ph_q <= 12'h000;
            scl_o_q <= 1'b1;
            scl_oe_q <= 1'b0;
          end
          else
            ph_q <= ph_q + 12'h001;
        end
        CCIT_ST_HIGH:
        begin
          if (ph_q >= hi_cyc - 12'h001)
          begin
            ph_q <= 12'h000;
            if (pulses_q == 4'(CCIT_RECOVER_PULSES - 1))
              rec_q <= CCIT_ST_IDLE; // see R14
            else
            begin
              pulses_q <= pulses_q + 4'h1;
              rec_q <= CCIT_ST_LOW;
              scl_o_q <= 1'b0;
              scl_oe_q <= 1'b1;
            end
          end
          else
            ph_q <= ph_q + 12'h001;
        end
        default: rec_q <= CCIT_ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // derived remote-access timing
  // ----------------------------------------------------------------
  // widest setup is 20 + 160 * 15 cycles, so 12 bits
  logic [11:0] setup_q;
  logic [7:0] delay_q;
  logic [11:0] hi_q;
  logic [11:0] lo_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      setup_q <= 12'h000;
      delay_q <= 8'h00;
      hi_q <= 12'h000;
      lo_q <= 12'h000;
    end
    else
    begin
      setup_q <= 12'(CCIT_SETUP_BASE_CYC + 32'(i2c_b_q[7:CCIT_SETUP_LSB])
                     * CCIT_SETUP_UNIT_CYC); // see R09
      delay_q <= 8'(CCIT_DLY_BASE_CYC + 32'(i2c_b_q[3:CCIT_DLY_LSB])
                    * CCIT_DLY_UNIT_CYC); // see R10
      hi_q <= hi_cyc;
      lo_q <= lo_cyc;
    end
  end
  assign o_reg_rdata = rdata_q;
  assign o_reg_wr_rejected = rej_q;
  assign o_link_abort = lw_abort_q;
  assign o_link_busy = lw_busy_q;
  assign o_scl = scl_o_q;
  assign o_scl_oe = scl_oe_q;
  assign o_bus_free = free_q;
  assign o_bus_recovering = scl_oe_q;
  assign o_sda_setup_cyc = setup_q;
  assign o_sda_delay_cyc = delay_q;
  assign o_scl_high_cyc = hi_q;
  assign o_scl_low_cyc = lo_q;
endmodule
`default_nettype wire

// ===== dv/ccit_bus_dev.sv
// local i2c bus device model: clocks frames, can hang sda low
`timescale 1ns/10ps
`default_nettype none
module ccit_bus_dev
(
  input wire logic i_run,
  input wire logic i_hang,
  output logic o_scl_low,
  output logic o_sda_low
);
  // scl moves only inside frames, 64 ns period, released between them
  initial o_scl_low = 1'b0;
  always #32 o_scl_low = i_run ? ~o_scl_low : 1'b0;
  // a hung slave holds sda; a released line floats to its pull-up
  assign o_sda_low = i_hang;
endmodule
`default_nettype wire

// ===== dv/ccit_top_sva.sv
// port assertions for the control channel timing block
`timescale 1ns/10ps
`default_nettype none
module ccit_top_sva
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_remote,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_reg_wr_rejected,
  input wire logic i_link_start,
  input wire logic i_link_done,
  input wire logic o_link_abort,
  input wire logic o_link_busy,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic o_bus_free,
  input wire logic [11:0] o_sda_setup_cyc,
  input wire logic [7:0] o_sda_delay_cyc,
  input wire logic [11:0] o_scl_high_cyc,
  input wire logic [11:0] o_scl_low_cyc
);
  // ------
  // shadow of accepted register writes
  // ------
  logic [7:0] w_q, a_q, b_q, h_q, l_q;
  logic [1:0] run_q;
  logic ok;
  assign ok = i_reg_wr && !(i_reg_remote && a_q[7]);
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      {w_q, a_q, b_q, h_q, l_q} <= 40'hfe1e107f7f;
      run_q <= 2'h0;
    end
    else
    begin
      run_q <= {run_q[0], 1'b1};
      if (ok)
        case (i_reg_addr)
          8'h08: w_q <= i_reg_wdata;
          8'h09: a_q <= i_reg_wdata;
          8'h0a: b_q <= i_reg_wdata;
          8'h0b: h_q <= i_reg_wdata;
          8'h0c: l_q <= i_reg_wdata;
          default: ;
        endcase
    end
  end
  // ------
  // assertions
  // ------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_start;
    i_link_start |=> o_link_busy;
  endproperty
  a_start: assert property (p_start) else $error("busy not set");
  property p_done;
    i_link_done && !i_link_start |=> !o_link_busy && !o_link_abort;
  endproperty
  a_done: assert property (p_done) else $error("timer kept on");
  property p_abort;
    o_link_abort |-> !o_link_busy && $past(o_link_busy);
  endproperty
  a_abort: assert property (p_abort) else $error("bad abort");
  property p_freeze;
    w_q[0] && o_link_busy |=> !o_link_abort;
  endproperty
  a_freeze: assert property (p_freeze) else $error("abort");
  property p_reject;
    i_reg_wr && i_reg_remote && a_q[7] |=> o_reg_wr_rejected;
  endproperty
  a_reject: assert property (p_reject) else $error("no reject");
  property p_local;
    i_reg_wr && !i_reg_remote |=> !o_reg_wr_rejected;
  endproperty
  a_local: assert property (p_local) else $error("local reject");
  property p_setup;
    run_q[1] |-> o_sda_setup_cyc == 12'(20 + 160 * $past(b_q[7:4]));
  endproperty
  a_setup: assert property (p_setup) else $error("bad setup");
  property p_delay;
    run_q[1] |-> o_sda_delay_cyc == 8'(60 + 10 * $past(b_q[3:2]));
  endproperty
  a_delay: assert property (p_delay) else $error("bad delay");
  property p_high;
    run_q[1] |-> o_scl_high_cyc == 12'(10 * ($past(h_q) + 5));
  endproperty
  a_high: assert property (p_high) else $error("bad high");
  property p_low;
    run_q[1] |-> o_scl_low_cyc == 12'(10 * ($past(l_q) + 5));
  endproperty
  a_low: assert property (p_low) else $error("bad low");
  property p_off;
    $past(b_q[0]) && $past(b_q[0], 2) |-> !$rose(o_scl_oe);
  endproperty
  a_off: assert property (p_off) else $error("watchdog ran");
  property p_pull;
    $rose(o_scl_oe) |-> !o_scl [*2];
  endproperty
  a_pull: assert property (p_pull) else $error("scl not low");
  c_abort: cover property (o_link_abort);
  c_reject: cover property (o_reg_wr_rejected);
  c_recover: cover property ($rose(o_scl_oe));
  c_free: cover property ($rose(o_bus_free));
endmodule
bind ccit_top ccit_top_sva u_sva
(
  .i_sys_clk, .i_reset_n, .i_reg_wr, .i_reg_remote, .i_reg_addr,
  .i_reg_wdata, .o_reg_wr_rejected, .i_link_start, .i_link_done,
  .o_link_abort, .o_link_busy, .o_scl, .o_scl_oe, .o_bus_free,
  .o_sda_setup_cyc, .o_sda_delay_cyc, .o_scl_high_cyc, .o_scl_low_cyc
);
`default_nettype wire

// ===== dv/ccit_top_tb.sv
// self-checking bench for the control channel timing block
`timescale 1ns/10ps
`default_nettype none
module ccit_top_tb
  import ccit_pkg::*;
;
  localparam int LU = 50;
  localparam int HF = 500;
  localparam int HS = 2000;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0, remote = 1'b0;
  logic start = 1'b0, done = 1'b0, run = 1'b0, hang = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, dly;
  logic rej, abort, busy, scl_o, oe, free, rec, scl_low, sda_low;
  logic [11:0] hi, lo, setup;
  int bad_count = 0, checked = 0;
  // open-drain lines: low if any party pulls
  wire scl_bus = ~(oe & ~scl_o) & ~scl_low;
  wire sda_bus = ~sda_low;
  always #2 clk = ~clk;
  ccit_top #(.LINK_UNIT_CYC(LU), .HANG_FAST_CYC(HF), .HANG_SLOW_CYC(HS)) dut
  (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd_s),
    .i_reg_remote(remote), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_wr_rejected(rej), .i_link_start(start),
    .i_link_done(done), .o_link_abort(abort), .o_link_busy(busy),
    .i_scl(scl_bus), .i_sda(sda_bus), .o_scl(scl_o), .o_scl_oe(oe),
    .o_bus_free(free), .o_bus_recovering(rec), .o_sda_setup_cyc(setup),
    .o_sda_delay_cyc(dly), .o_scl_high_cyc(hi), .o_scl_low_cyc(lo)
  );
  ccit_bus_dev u_dev
  (
    .i_run(run), .i_hang(hang), .o_scl_low(scl_low), .o_sda_low(sda_low)
  );
  // ------
  // helpers
  // ------
  task automatic cmp(input string n, input logic [11:0] e,
    input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input int l, input int h, input int g);
    checked++;
    if (g < l || g > h)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, l, h, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d,
    input logic r);
    @(negedge clk);
    {wr, remote, addr, wdata} = {1'b1, r, a, d};
    @(negedge clk);
    {wr, remote} = 2'b00;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {rd_s, addr} = {1'b1, a};
    @(negedge clk);
    rd_s = 1'b0;
    cmp("read data", {4'h0, e}, {4'h0, rdata});
  endtask
  // cycles until free (sel) or oe rises, lim if never
  task automatic wait_on(input bit sel, input int lim, output int n);
    n = 0;
    while (n < lim && (sel ? free : oe) !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic link_run(output int n);
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 1;
    while (n < 400 && abort !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    logic [7:0] rst_v [6] = '{8'hfe, 8'h1e, 8'h10, 8'h7f, 8'h7f, 8'h00};
    for (int i = 0; i < 6; i++)
      rreg(8'h08 + 8'(i), rst_v[i]);
    wreg(8'h09, 8'h80, 1'b0);
    cmp("local write", 1'b0, rej);
    wreg(8'h0b, 8'h33, 1'b1);
    cmp("remote write", 1'b1, rej);
    rreg(8'h0b, 8'h7f);
    wreg(8'h09, 8'h1e, 1'b1);
    rreg(8'h09, 8'h80);
    wreg(8'h09, 8'h1e, 1'b0);
    wreg(8'h0b, 8'h00, 1'b1);
    cmp("remote write", 1'b0, rej);
    rreg(8'h0b, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_time();
    for (int d = 0; d < 4; d++)
    begin
      wreg(8'h0a, 8'(d << 2), 1'b0);
      tick(3);
      cmp("delay", 12'(CCIT_DLY_BASE_CYC + d * CCIT_DLY_UNIT_CYC),
        12'(dly));
    end
    cmp("setup", 12'(CCIT_SETUP_BASE_CYC), setup);
    wreg(8'h0a, 8'h12, 1'b0);
    tick(3);
    cmp("setup", 12'(CCIT_SETUP_BASE_CYC + CCIT_SETUP_UNIT_CYC),
      setup);
    wreg(8'h0a, 8'hf0, 1'b0);
    tick(3);
    cmp("setup max", 12'(CCIT_SETUP_BASE_CYC + 15 * CCIT_SETUP_UNIT_CYC),
      setup);
    for (int v = 255; v >= 0; v -= 255)
    begin
      wreg(8'h0b, 8'(v), 1'b0);
      wreg(8'h0c, 8'(v), 1'b0);
      tick(3);
      cmp("high", 12'((v + 5) * CCIT_OSC_CYC), hi);
      cmp("low", 12'((v + 5) * CCIT_OSC_CYC), lo);
    end
    $display("test timing done");
  endtask
  task automatic t_link();
    int n;
    // count two aborts after two units; zero is never programmed
    wreg(8'h08, 8'h04, 1'b0);
    link_run(n);
    rng("abort time", 2 * LU, 2 * LU + 6, n);
    cmp("busy after abort", 1'b0, busy);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(80);
    link_run(n);
    rng("restart", 2 * LU, 2 * LU + 6, n);
    wreg(8'h08, 8'h05, 1'b0);
    link_run(n);
    rng("frozen", 400, 400, n);
    cmp("busy frozen", 1'b1, busy);
    done = 1'b1;
    tick(1);
    done = 1'b0;
    cmp("busy after done", 1'b0, busy);
    wreg(8'h08, 8'hfe, 1'b0);
    $display("test link done");
  endtask
  task automatic t_hang();
    int n;
    int ups;
    logic p;
    // bench scl halves last 8 cycles; keep the filter below that
    wreg(8'h09, 8'h12, 1'b0);
    wreg(8'h0a, 8'h03, 1'b0);
    hang = 1'b1;
    wait_on(1'b0, 800, n);
    rng("disabled", 800, 800, n);
    run = 1'b1;
    tick(100);
    wreg(8'h0a, 8'h02, 1'b0);
    wait_on(1'b0, 1000, n);
    rng("active bus", 1000, 1000, n);
    run = 1'b0;
    wait_on(1'b0, HF + 200, n);
    rng("hang expiry", HF, HF + 100, n);
    cmp("recovering", 12'h001, 12'(rec));
    cmp("scl drive", 12'h000, 12'(scl_o));
    ups = 1;
    p = 1'b1;
    repeat (1200)
    begin
      @(negedge clk);
      if (oe === 1'b1 && !p) ups++;
      p = oe;
    end
    cmp("pulses", 12'(CCIT_RECOVER_PULSES), 12'(ups));
    hang = 1'b0;
    wait_on(1'b1, HF + 200, n);
    rng("free fast", HF, HF + 100, n);
    wreg(8'h0a, 8'h00, 1'b0);
    run = 1'b1;
    tick(80);
    run = 1'b0;
    cmp("free cleared", 1'b0, free);
    wait_on(1'b1, HS + 200, n);
    rng("free slow", HS, HS + 100, n);
    $display("test hang done");
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(16);
    rst_n = 1'b1;
    tick(2);
    t_regs();
    t_time();
    t_link();
    t_hang();
    summarize();
  end
  // about seven times the expected run length
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
